//--- logic/dbsp_cfg.svh
// constants for the burst sram port
// Operation
// - An address is taken only on every other rising edge of the input clock, and the controller keeps that step.
// - Write data is caught on the rising edge of the input clock and again on its falling edge, one word each.
// - Read data words are launched on both clock phases, two words for each clock cycle.
// - One address selects a pair of 36-bit words (18-bit in the narrow build) moved back to back as a burst.
// - With the pll-disable input high, the first read word comes out 2.5 cycles after the address is taken.
// - With the pll-disable input low, read data comes out with a latency of one cycle.
// - The read-valid output is high exactly while valid read data is on the data outputs.
// - A pair of echo clocks aligned with the read data is driven out for the controller to capture with.
// - Every synchronous input passes an input register on the input clock or its complement before use.
// - Every data output leaves from an output register on the input clock or its complement.
// - A write burst is stored by internal self-timed logic with no further controller action; here a burst is lost if the buffer is full (wr_buf_ready low).
// - Read and write data share one two-way bus, each side releasing it while the other drives.
// - The array holds 144 Mbit, as 4M words of 36 bits here or 8M words of 18 bits in the narrow build.
`ifndef DBSP_CFG_SVH
`define DBSP_CFG_SVH

// wide organisation; narrow build uses 18 and 22
`define DBSP_WORD_W 36
`define DBSP_ADDR_W 21
`define DBSP_BURST_LEN 2
// read latency in half cycles
`define DBSP_LAT_LONG_HALF 5
`define DBSP_LAT_SHORT_HALF 2
`define DBSP_BUF_DEPTH 2

`endif

//--- logic/dbsp_pkg.sv
// types for the burst sram port
`include "dbsp_cfg.svh"

package dbsp_pkg;

   typedef logic [`DBSP_WORD_W-1:0] dbsp_word_t;
   typedef logic [`DBSP_ADDR_W-1:0] dbsp_addr_t;
   typedef logic [`DBSP_BURST_LEN*`DBSP_WORD_W-1:0] dbsp_burst_t;

   typedef struct packed {
      dbsp_addr_t addr;
      dbsp_burst_t data;
   } dbsp_wr_s;

   // address slot, gray along the alternating path
   typedef enum logic {
      DBSP_SLOT_ADDR = 1'b0,
      DBSP_SLOT_DATA = 1'b1
   } dbsp_slot_e;

   typedef enum logic {
      DBSP_LAT_SHORT = 1'b0,
      DBSP_LAT_LONG = 1'b1
   } dbsp_lat_e;

endpackage

//--- logic/dbsp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps

module dbsp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      meta <= d;
      q <= meta;
   end

endmodule

//--- logic/dbsp_buf.sv
// two-entry valid/ready buffer
`timescale 1ns/1ps

module dbsp_buf #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] mem [0:DEPTH-1];
   logic [PW-1:0] wptr;
   logic [PW-1:0] rptr;
   logic [PW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != DEPTH[PW:0]);
   assign out_valid = (count != '0);
   assign out_data = mem[rptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         if (push) begin
            wptr <= (wptr == PW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
         end
         if (pop) begin
            rptr <= (rptr == PW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= count + 1'b1;
      end else if (pop && !push) begin
         count <= count - 1'b1;
      end
   end

   full_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
      (count == DEPTH[PW:0]) |-> !in_ready && out_valid)
      else $error("full buffer still accepts words");

endmodule

//--- logic/dbsp_top.sv
// double data rate burst sram port with self-timed write commit
`timescale 1ns/1ps
`include "dbsp_cfg.svh"

module dbsp_top
   import dbsp_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic link_clk,
   input wire logic load_n,
   input wire logic read_not_write,
   input wire logic [`DBSP_ADDR_W-1:0] addr,
   input wire logic [`DBSP_WORD_W-1:0] dq_i,
   output logic [`DBSP_WORD_W-1:0] dq_o,
   output logic dq_oe,
   input wire logic pll_disable_input,
   output logic read_echo_clock,
   output logic read_echo_clock_n,
   output logic read_valid_flag,
   output logic wr_buf_ready
);

   // pick one word of a burst
   function automatic dbsp_word_t burst_word(input dbsp_burst_t b, input logic idx);
      burst_word = idx ? b[2*`DBSP_WORD_W-1:`DBSP_WORD_W] : b[`DBSP_WORD_W-1:0];
   endfunction

   // ---------------------------------------------------------------
   // link reset and mode, brought into the link clock
   // ---------------------------------------------------------------
   logic k_rst_n;
   logic pll_dis_s;
   dbsp_lat_e lat;

   dbsp_sync #(
      .W(2)
   ) u_sync_link (
      .clk(link_clk),
      .d({rstn, pll_disable_input}),
      .q({k_rst_n, pll_dis_s})
   );

   assign lat = pll_dis_s ? DBSP_LAT_LONG : DBSP_LAT_SHORT;

   // ---------------------------------------------------------------
   // input registers and address slot
   // ---------------------------------------------------------------
   dbsp_slot_e slot;
   dbsp_slot_e in_slot;
   logic in_load_n;
   logic in_rnw;
   dbsp_addr_t in_addr;
   dbsp_word_t wd_rise;
   dbsp_word_t wd_fall;
   logic acc;
   logic acc_rd;
   logic acc_wr;

   always_ff @(posedge link_clk) begin
      if (!k_rst_n) begin
         slot <= DBSP_SLOT_ADDR;
      end else begin
         slot <= (slot == DBSP_SLOT_ADDR) ? DBSP_SLOT_DATA : DBSP_SLOT_ADDR;
      end
   end

   always_ff @(posedge link_clk) begin
      if (!k_rst_n) begin
         in_slot <= DBSP_SLOT_DATA;
         in_load_n <= 1'b1;
         in_rnw <= 1'b1;
         in_addr <= '0;
      end else begin
         in_slot <= slot;
         in_load_n <= load_n;
         in_rnw <= read_not_write;
         in_addr <= addr;
      end
   end

   // write data input registers, one per phase
   always_ff @(posedge link_clk) begin
      if (!k_rst_n) begin
         wd_rise <= '0;
      end else begin
         wd_rise <= dq_i;
      end
   end

   always_ff @(negedge link_clk) begin
      if (!k_rst_n) begin
         wd_fall <= '0;
      end else begin
         wd_fall <= dq_i;
      end
   end

   // only every other rising edge can take an address
   assign acc = (in_slot == DBSP_SLOT_ADDR) && !in_load_n;
   assign acc_rd = acc && in_rnw;
   assign acc_wr = acc && !in_rnw;

   addr_alt_a: assert property (@(posedge link_clk) disable iff (!k_rst_n)
      acc |=> !acc)
      else $error("address taken on two edges in a row");

   // ---------------------------------------------------------------
   // self-timed write path: buffer, then handshake into mclk
   // ---------------------------------------------------------------
   logic wr_s1;
   dbsp_addr_t wr_a1;
   dbsp_wr_s buf_in;
   dbsp_wr_s buf_out;
   logic buf_out_valid;
   logic buf_out_ready;
   dbsp_wr_s hs_data;
   logic req_tgl;
   logic ack_k;
   logic busy;

   always_ff @(posedge link_clk) begin
      if (!k_rst_n) begin
         wr_s1 <= 1'b0;
         wr_a1 <= '0;
      end else begin
         wr_s1 <= acc_wr;
         wr_a1 <= in_addr;
      end
   end

   // first word on the rising edge, second on the falling edge
   assign buf_in.addr = wr_a1;
   assign buf_in.data = {wd_fall, wd_rise};

   dbsp_buf #(
      .W($bits(dbsp_wr_s)),
      .DEPTH(`DBSP_BUF_DEPTH)
   ) u_wr_buf (
      .clk(link_clk),
      .rst_n(k_rst_n),
      .in_valid(wr_s1),
      .in_ready(wr_buf_ready),
      .in_data(buf_in),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out)
   );

   assign busy = (req_tgl != ack_k);
   assign buf_out_ready = !busy;

   always_ff @(posedge link_clk) begin
      if (!k_rst_n) begin
         req_tgl <= 1'b0;
         hs_data <= '0;
      end else if (buf_out_valid && !busy) begin
         req_tgl <= ~req_tgl;
         hs_data <= buf_out;
      end
   end

   wr_push_a: assert property (@(posedge link_clk) disable iff (!k_rst_n)
      wr_s1 && wr_buf_ready |=> buf_out_valid || busy)
      else $error("captured write burst not queued");

   hs_hold_a: assert property (@(posedge link_clk) disable iff (!k_rst_n)
      busy && $past(busy) |-> $stable(hs_data))
      else $error("write payload moved during handshake");

   // ---------------------------------------------------------------
   // core array and commit engine on mclk
   // ---------------------------------------------------------------
   dbsp_burst_t core [0:(1 << `DBSP_ADDR_W) - 1];
   logic req_m;
   logic req_seen;
   logic commit;

   dbsp_sync #(
      .W(1)
   ) u_sync_req (
      .clk(mclk),
      .d(req_tgl),
      .q(req_m)
   );

   dbsp_sync #(
      .W(1)
   ) u_sync_ack (
      .clk(link_clk),
      .d(req_seen),
      .q(ack_k)
   );

   assign commit = (req_m != req_seen);

   // payload is held stable until the ack returns
   always_ff @(posedge mclk) begin
      if (commit) begin
         core[hs_data.addr] <= hs_data.data;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         req_seen <= 1'b0;
      end else begin
         req_seen <= req_m;
      end
   end

   commit_once_a: assert property (@(posedge mclk) disable iff (!rstn)
      commit |=> !commit && req_seen == $past(req_m))
      else $error("write commit not completed in one cycle");

   // ---------------------------------------------------------------
   // read pipeline and output registers
   // ---------------------------------------------------------------
   // a word still awaiting commit reads back its old contents
   dbsp_burst_t rd_word;
   logic rd_s1;
   logic rd_s2;
   dbsp_burst_t rd_d1;
   dbsp_burst_t rd_d2;
   dbsp_word_t q_rise;
   dbsp_word_t q_fall;
   logic v_rise;
   logic v_fall;

   assign rd_word = core[in_addr];

   always_ff @(posedge link_clk) begin
      if (!k_rst_n) begin
         rd_s1 <= 1'b0;
         rd_s2 <= 1'b0;
         rd_d1 <= '0;
         rd_d2 <= '0;
      end else begin
         rd_s1 <= acc_rd;
         rd_s2 <= rd_s1;
         rd_d1 <= rd_word;
         rd_d2 <= rd_d1;
      end
   end

   // rising-phase output register
   always_ff @(posedge link_clk) begin
      if (!k_rst_n) begin
         q_rise <= '0;
         v_rise <= 1'b0;
      end else if (lat == DBSP_LAT_SHORT) begin
         q_rise <= burst_word(rd_word, 1'b0);
         v_rise <= acc_rd;
      end else begin
         q_rise <= burst_word(rd_d2, 1'b1);
         v_rise <= rd_s2;
      end
   end

   // falling-phase output register
   always_ff @(negedge link_clk) begin
      if (!k_rst_n) begin
         q_fall <= '0;
         v_fall <= 1'b0;
      end else if (lat == DBSP_LAT_SHORT) begin
         q_fall <= burst_word(rd_d1, 1'b1);
         v_fall <= rd_s1;
      end else begin
         q_fall <= burst_word(rd_d2, 1'b0);
         v_fall <= rd_s2;
      end
   end

   // phase select of the two output registers
   assign dq_o = link_clk ? q_rise : q_fall;
   assign read_valid_flag = link_clk ? v_rise : v_fall;
   assign dq_oe = read_valid_flag;
   assign read_echo_clock = link_clk;
   assign read_echo_clock_n = ~link_clk;

   lat_short_a: assert property (@(posedge link_clk) disable iff (!k_rst_n)
      acc_rd && lat == DBSP_LAT_SHORT |=> v_rise && q_rise == burst_word($past(rd_word), 1'b0))
      else $error("short latency read word not on the next rising edge");

   // first word in the low half after two cycles, second in the next high half
   lat_long_a: assert property (@(posedge link_clk) disable iff (!k_rst_n)
      acc_rd && lat == DBSP_LAT_LONG && $stable(lat) |-> ##2 (!v_rise && v_fall) ##1 (v_rise && !v_fall))
      else $error("long latency read not at two and a half cycles");

   short_pair_a: assert property (@(posedge link_clk) disable iff (!k_rst_n)
      rd_s1 && lat == DBSP_LAT_SHORT |-> v_fall && q_fall == burst_word(rd_d1, 1'b1))
      else $error("second burst word missing on falling phase");

   valid_cause_a: assert property (@(posedge link_clk) disable iff (!k_rst_n)
      v_rise |-> $past(acc_rd) || $past(rd_s2))
      else $error("read valid without a read in flight");

   no_drive_wr_a: assert property (@(posedge link_clk) disable iff (!k_rst_n)
      wr_s1 && lat == DBSP_LAT_SHORT |-> !v_rise)
      else $error("data bus driven while write data arrives");

   // sampled just before the fall, while the rising-phase word is shown
   echo_align_a: assert property (@(negedge link_clk) disable iff (!k_rst_n)
      read_echo_clock && !read_echo_clock_n && dq_o == q_rise)
      else $error("echo clock out of step with read data");

endmodule

//--- verif/dbsp_ctrl_model.sv
// memory controller model for the burst sram port
`timescale 1ns/1ps
`include "dbsp_cfg.svh"

module dbsp_ctrl_model
   import dbsp_pkg::*;
(
   input wire logic link_clk,
   input wire logic rstn,
   input wire logic read_echo_clock,
   input wire logic [`DBSP_WORD_W-1:0] dq_o,
   input wire logic dq_oe,
   input wire logic read_valid_flag,
   input wire logic wr_buf_ready,
   output logic load_n,
   output logic read_not_write,
   output logic [`DBSP_ADDR_W-1:0] addr,
   output logic [`DBSP_WORD_W-1:0] dq_i
);
   // ---
   // slot tracking
   // ---
   int cnt = 0;
   logic saw_full = 1'b0;

   initial begin
      load_n = 1'b1;
      read_not_write = 1'b1;
      addr = '0;
      dq_i = '0;
   end

   // third edge with reset gone is the first address slot
   always @(posedge link_clk) begin
      cnt <= rstn ? cnt + 1 : 0;
      if (cnt > 4 && !wr_buf_ready) begin
         saw_full <= 1'b1;
      end
   end

   // ---
   // transfers
   // ---
   task automatic issue(input logic rd, input dbsp_addr_t a, input bit slot);
      while (link_clk !== 1'b0 || ((cnt >= 2 && !cnt[0]) != slot)) begin
         @(negedge link_clk);
      end
      load_n <= 1'b0;
      read_not_write <= rd;
      addr <= a;
      @(negedge link_clk);
      load_n <= 1'b1;
      addr <= ~a;
   endtask

   task automatic write(input dbsp_addr_t a, input dbsp_burst_t b);
      issue(1'b0, a, 1'b1);
      dq_i <= b[`DBSP_WORD_W-1:0];
      @(posedge link_clk);
      dq_i <= b[2*`DBSP_WORD_W-1:`DBSP_WORD_W];
      @(negedge link_clk);
      dq_i <= ~b[2*`DBSP_WORD_W-1:`DBSP_WORD_W];
   endtask

   task automatic read(input dbsp_addr_t a, input bit slot, output dbsp_word_t q[8],
                       output logic [7:0] v, output logic [7:0] oe);
      v = '0;
      oe = '0;
      issue(1'b1, a, slot);
      // one sample an eighth of a cycle into each echo half
      for (int k = 1; k < 8; k++) begin
         #8;
         q[k] = dq_o;
         v[k] = read_valid_flag;
         oe[k] = dq_oe;
         @(read_echo_clock);
      end
   endtask
endmodule

//--- verif/dbsp_top_tb.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
`include "dbsp_cfg.svh"

module dbsp_top_tb import dbsp_pkg::*;;
   localparam dbsp_burst_t B0 = 72'hC3A50F1E2D4B6987F0;
   logic mclk = 1'b0;
   logic link_clk = 1'b0;
   logic rstn = 1'b0;
   logic pll_disable_input = 1'b0;
   logic load_n, read_not_write, dq_oe, read_valid_flag, wr_buf_ready;
   logic read_echo_clock, read_echo_clock_n;
   dbsp_addr_t addr;
   dbsp_word_t dq_i, dq_o;
   int miscompares = 0;
   int n_compared = 0;

   always #20 mclk = ~mclk;

   // link clock offset so its edges never meet the core clock's
   initial begin
      #7;
      forever #32 link_clk = ~link_clk;
   end

   dbsp_top dbsp_top_i (.mclk(mclk), .rstn(rstn), .link_clk(link_clk), .load_n(load_n),
      .read_not_write(read_not_write), .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
      .pll_disable_input(pll_disable_input), .read_echo_clock(read_echo_clock),
      .read_echo_clock_n(read_echo_clock_n), .read_valid_flag(read_valid_flag),
      .wr_buf_ready(wr_buf_ready));

   dbsp_ctrl_model dbsp_ctrl_model_i (.link_clk(link_clk), .rstn(rstn), .read_echo_clock(read_echo_clock),
      .dq_o(dq_o), .dq_oe(dq_oe), .read_valid_flag(read_valid_flag), .wr_buf_ready(wr_buf_ready),
      .load_n(load_n), .read_not_write(read_not_write), .addr(addr), .dq_i(dq_i));

   // ---
   // checking
   // ---
   task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("miscompares %0d compared %0d", miscompares, n_compared);
      if (miscompares == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ---
   // scenarios
   // ---
   task automatic t_reset;
      check("oe in reset", dq_oe, 1'b0);
      check("valid in reset", read_valid_flag, 1'b0);
      check("dq in reset", dq_o, '0);
      check("ready in reset", wr_buf_ready, 1'b1);
   endtask

   task automatic t_echo;
      repeat (4) begin
         @(posedge mclk);
         #1;
         check("echo", read_echo_clock, link_clk);
         check("echo inverse", read_echo_clock_n, !link_clk);
      end
   endtask

   task automatic set_lat(input logic long);
      @(negedge mclk);
      pll_disable_input = long;
      repeat (4) @(posedge link_clk);
   endtask

   task automatic t_rd(input dbsp_addr_t a, input dbsp_burst_t b, input logic long);
      dbsp_word_t q[8];
      logic [7:0] v;
      logic [7:0] oe;
      logic [7:0] m;
      int h;
      // sample k lies k half cycles after the address edge
      h = long ? `DBSP_LAT_LONG_HALF : `DBSP_LAT_SHORT_HALF;
      m = 8'h03 << h;
      dbsp_ctrl_model_i.read(a, 1'b1, q, v, oe);
      check("valid halves", v, m);
      check("oe halves", oe, m);
      check("word0", q[h], b[35:0]);
      check("word1", q[h + 1], b[71:36]);
   endtask

   task automatic t_slot;
      dbsp_word_t q[8];
      logic [7:0] v;
      logic [7:0] oe;
      dbsp_ctrl_model_i.read('1, 1'b0, q, v, oe);
      check("off slot valid", v, 8'h00);
      check("off slot oe", oe, 8'h00);
   endtask

   task automatic t_fill;
      for (int i = 0; i < 8; i++) begin
         dbsp_ctrl_model_i.write(dbsp_addr_t'(16 + i), B0 ^ dbsp_burst_t'(i));
      end
      check("buffer full seen", dbsp_ctrl_model_i.saw_full, 1'b1);
      repeat (30) @(posedge link_clk);
      check("buffer drained", wr_buf_ready, 1'b1);
      t_rd(dbsp_addr_t'(16), B0, 1'b1);
      t_rd(dbsp_addr_t'(17), B0 ^ 72'h1, 1'b1);
   endtask

   initial begin
      repeat (8) @(negedge mclk);
      t_reset;
      rstn = 1'b1;
      t_echo;
      set_lat(1'b0);
      dbsp_ctrl_model_i.write('1, B0);
      repeat (12) @(posedge link_clk);
      t_rd('1, B0, 1'b0);
      set_lat(1'b1);
      t_rd('1, B0, 1'b1);
      t_slot;
      t_fill;
      conclude;
   end

   // hang guard, far beyond the few microseconds the tests need
   initial begin
      #100000;
      miscompares++;
      conclude;
   end
endmodule
